/* verilog/csd_drive.sv */
// Cyclic velocity/torque and step/direction operating-mode logic
//
// Operation
// - Mode code 9 selects cyclic synchronous velocity, no ramps.
// - Mode code 10 selects cyclic synchronous torque, no ramps.
// - Mode code FFh (-1) selects step/direction operation.
// - Control word bits carry no meaning in cyclic modes.
// - Status bit 8 shows sync with the fieldbus cycle in cyclic modes.
// - Status bit 12 set while the target drives the loop, else clear.
// - Cycle is period times 10^index seconds; only index -3 accepted.
// - Torque is clamped to min of max torque and max current.
// - Torque mode works only with closed loop enabled.
// - Torque offset in tenths of percent is added to setpoint.
// - Quick stop brakes with its deceleration in velocity mode, zeroes torque in torque mode, and applies its option.
// - Each pulse moves one step in the indicated direction.
// - Pulses are buffered per cycle, demand position updated once per cycle.
// - Brushless motor handled as stepper, four full steps per pole pair.
// - Bit 13 flags following error beyond window longer than timeout.
// - Subtype 0 is pulse plus direction, subtype 1 is dual pulse.
// - Input 1 is the pulse input; input 2 is the direction input in subtype 0 and the reverse pulse input in subtype 1.
`timescale 1ns/100ps
module csd_drive
    import csd_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int SPW    = 16
) (
    // Core clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Fieldbus side, link clock
    input  wire logic            bus_clk,
    input  wire logic            mode_wr,
    input  wire logic [7:0]      mode_code,
    input  wire logic            sp_wr,
    input  wire logic [SPW-1:0]  sp_val,
    input  wire logic            sync_evt,
    output logic                 mode_busy,
    output logic                 sp_busy,
    // Configuration
    input  wire logic [7:0]      ip_period,
    input  wire logic [7:0]      ip_index,
    input  wire logic [SPW-1:0]  max_speed,
    input  wire logic [SPW-1:0]  max_torque,
    input  wire logic [SPW-1:0]  max_current,
    input  wire logic [SPW-1:0]  vel_offset,
    input  wire logic [SPW-1:0]  torque_offset,
    input  wire logic [SPW-1:0]  qs_decel,
    input  wire logic [2:0]      qs_option,
    input  wire logic            quick_stop,
    input  wire logic            closed_loop,
    input  wire logic            sd_subtype,
    input  wire logic [15:0]     scale_num,
    input  wire logic [15:0]     scale_den,
    input  wire logic [7:0]      pole_pairs,
    input  wire logic [31:0]     ferr_window,
    input  wire logic [15:0]     ferr_timeout,
    input  wire logic [31:0]     actual_pos,
    // Digital input pins
    input  wire logic            din1,
    input  wire logic            din2,
    // Results
    output logic [15:0]          status_word,
    output logic [SPW-1:0]       vel_cmd,
    output logic [SPW-1:0]       torque_cmd,
    output logic [31:0]          demand_pos,
    output logic                 qs_active,
    output logic [2:0]           qs_option_out,
    output logic [15:0]          steps_per_rev,
    output logic                 cycle_tick
);
    csd_mode_t          mode;
    logic               mode_new;
    logic [7:0]         mode_data;
    logic               sp_new;
    logic [SPW-1:0]     sp_data;
    logic               sync_new;
    logic [31:0]        ms_cnt;
    logic               ms_tick;
    logic [7:0]         per_cnt;
    logic               ip_ok;
    logic               sync_seen;
    logic               in_sync;
    logic               sp_seen;
    logic               sp_fresh;
    logic               cyclic;
    logic               follow;
    logic               din1_s;
    logic               din2_s;
    logic               din1_d;
    logic               din2_d;
    logic               rise1;
    logic               rise2;
    logic signed [1:0]  delta;
    logic signed [15:0] acc;
    logic signed [15:0] next_acc;
    logic signed [32:0] scaled;
    logic signed [31:0] pos_err;
    logic [31:0]        err_mag;
    logic [15:0]        ferr_ms;
    logic               ferr;
    logic signed [SPW+1:0] vel_sum;
    logic signed [SPW+1:0] vel_lim;
    logic signed [SPW+1:0] trq_sum;
    logic signed [SPW+1:0] trq_lim;
    logic [SPW-1:0]        lim_t;

    // ------------------------------------------------------------
    // Link crossings
    // ------------------------------------------------------------
    csd_xfer #(.W(8)) u_mode (
        .src_clk(bus_clk), .dst_clk(clk), .rst(sys_rst),
        .src_valid(mode_wr), .src_data(mode_code), .src_busy(mode_busy),
        .dst_valid(mode_new), .dst_data(mode_data));
    csd_xfer #(.W(SPW)) u_sp (
        .src_clk(bus_clk), .dst_clk(clk), .rst(sys_rst),
        .src_valid(sp_wr), .src_data(sp_val), .src_busy(sp_busy),
        .dst_valid(sp_new), .dst_data(sp_data));
    csd_xfer #(.W(1)) u_sync (
        .src_clk(bus_clk), .dst_clk(clk), .rst(sys_rst),
        .src_valid(sync_evt), .src_data(1'b1), .src_busy(),
        .dst_valid(sync_new), .dst_data());
    csd_sync2 #(.W(2)) u_din (
        .clk(clk), .rst(sys_rst), .d({din2, din1}), .q({din2_s, din1_s}));

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= MODE_NONE;
        end else if (mode_new) begin
            unique case (mode_data)
                CODE_CSV: mode <= MODE_CSV;
                CODE_CST: mode <= MODE_CST;
                CODE_SD:  mode <= MODE_SD;
                default:  mode <= MODE_NONE;
            endcase
        end
    end

    assign cyclic = (mode == MODE_CSV) || (mode == MODE_CST);

    // ------------------------------------------------------------
    // Interpolation cycle timer
    // ------------------------------------------------------------
    assign ip_ok   = (ip_index == IDX_MS) && (ip_period != 8'h00);
    assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_tick ? '0 : ms_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            per_cnt    <= '0;
            cycle_tick <= 1'b0;
        end else begin
            cycle_tick <= 1'b0;
            if (!ip_ok) begin
                per_cnt <= '0;
            end else if (ms_tick) begin
                if (per_cnt >= ip_period - 8'h01) begin
                    per_cnt    <= '0;
                    cycle_tick <= 1'b1;
                end else begin
                    per_cnt <= per_cnt + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sync and setpoint freshness per cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_seen <= 1'b0;
            in_sync   <= 1'b0;
            sp_seen   <= 1'b0;
            sp_fresh  <= 1'b0;
        end else begin
            if (cycle_tick) begin
                in_sync   <= sync_seen || sync_new;
                sp_fresh  <= sp_seen || sp_new;
                sync_seen <= sync_new;
                sp_seen   <= sp_new;
            end else begin
                sync_seen <= sync_seen || sync_new;
                sp_seen   <= sp_seen || sp_new;
                if (!ip_ok) begin
                    in_sync  <= 1'b0;
                    sp_fresh <= 1'b0;
                end
            end
        end
    end

    // Target drives the loop only when fresh, not stopping, loop allowed
    assign follow = cyclic && sp_fresh && !quick_stop
                    && (mode != MODE_CST || closed_loop);

    // ------------------------------------------------------------
    // Velocity and torque setpoints
    // ------------------------------------------------------------
    assign vel_sum = (SPW+2)'($signed(sp_data)) + (SPW+2)'($signed(vel_offset));
    assign trq_sum = (SPW+2)'($signed(sp_data)) + (SPW+2)'($signed(torque_offset));
    assign lim_t   = (max_torque < max_current) ? max_torque : max_current;

    always_comb begin
        vel_lim = vel_sum;
        if (vel_sum > $signed({2'b00, max_speed})) begin
            vel_lim = $signed({2'b00, max_speed});
        end else if (vel_sum < -$signed({2'b00, max_speed})) begin
            vel_lim = -$signed({2'b00, max_speed});
        end
        trq_lim = trq_sum;
        if (trq_sum > $signed({2'b00, lim_t})) begin
            trq_lim = $signed({2'b00, lim_t});
        end else if (trq_sum < -$signed({2'b00, lim_t})) begin
            trq_lim = -$signed({2'b00, lim_t});
        end
    end

    // Quick stop ramps speed to zero at its deceleration per millisecond
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vel_cmd <= '0;
        end else if (mode != MODE_CSV) begin
            vel_cmd <= '0;
        end else if (quick_stop) begin
            if (ms_tick) begin
                if ($signed(vel_cmd) > $signed(qs_decel)) begin
                    vel_cmd <= vel_cmd - qs_decel;
                end else if ($signed(vel_cmd) < -$signed(qs_decel)) begin
                    vel_cmd <= vel_cmd + qs_decel;
                end else begin
                    vel_cmd <= '0;
                end
            end
        end else if (follow && sp_new) begin
            vel_cmd <= SPW'(vel_lim);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            torque_cmd <= '0;
        end else if (mode != MODE_CST || !closed_loop || quick_stop) begin
            torque_cmd <= '0;
        end else if (sp_new) begin
            torque_cmd <= SPW'(trq_lim);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            qs_active     <= 1'b0;
            qs_option_out <= '0;
        end else begin
            qs_active <= cyclic && quick_stop;
            if (cyclic && quick_stop && !qs_active) begin
                qs_option_out <= qs_option;
            end
        end
    end

    // ------------------------------------------------------------
    // Step/direction pulse counting
    // ------------------------------------------------------------
    assign rise1 = din1_s && !din1_d;
    assign rise2 = din2_s && !din2_d;

    always_comb begin
        delta = 2'sd0;
        if (sd_subtype == SUB_PULSE_DIR) begin
            if (rise1) begin
                delta = din2_s ? -2'sd1 : 2'sd1;
            end
        end else begin
            if (rise1 && !rise2) begin
                delta = 2'sd1;
            end else if (rise2 && !rise1) begin
                delta = -2'sd1;
            end
        end
        next_acc = (cycle_tick ? 16'sd0 : acc) + 16'(delta);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            din1_d <= 1'b0;
            din2_d <= 1'b0;
            acc    <= '0;
        end else begin
            din1_d <= din1_s;
            din2_d <= din2_s;
            acc    <= (mode == MODE_SD) ? next_acc : 16'sd0;
        end
    end

    // Denominator zero is treated as one to avoid a divide fault
    assign scaled = ($signed(33'(acc)) * $signed({17'h0, scale_num}))
                    / $signed({17'h0, (scale_den == 16'h0) ? 16'h1 : scale_den});

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            demand_pos <= '0;
        end else if (mode == MODE_SD && cycle_tick) begin
            demand_pos <= demand_pos + 32'(scaled);
        end
    end

    assign steps_per_rev = 16'(FULL_STEPS_PP) * {8'h00, pole_pairs};

    // ------------------------------------------------------------
    // Following error watch
    // ------------------------------------------------------------
    assign pos_err = $signed(demand_pos) - $signed(actual_pos);
    assign err_mag = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ferr_ms <= '0;
            ferr    <= 1'b0;
        end else if (mode != MODE_SD || !closed_loop || err_mag <= ferr_window) begin
            ferr_ms <= '0;
            ferr    <= 1'b0;
        end else begin
            if (ms_tick && ferr_ms != 16'hffff) begin
                ferr_ms <= ferr_ms + 16'h1;
            end
            ferr <= (ferr_ms > ferr_timeout);
        end
    end

    // ------------------------------------------------------------
    // Status word, no control word bits consulted
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_word <= '0;
        end else begin
            status_word            <= '0;
            status_word[SW_SYNC]   <= cyclic && in_sync;
            status_word[SW_FOLLOW] <= follow;
            status_word[SW_FERR]   <= ferr;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence tick_s;
        cycle_tick && mode == MODE_SD && delta == 2'sd0;
    endsequence
    sequence cleared_s;
        acc == 16'sd0;
    endsequence

    mode_csv_a: assert property (mode_new && mode_data == CODE_CSV |=> mode == MODE_CSV)
        else $error("code 9 did not select velocity mode");
    mode_cst_a: assert property (mode_new && mode_data == CODE_CST |=> mode == MODE_CST)
        else $error("code 10 did not select torque mode");
    mode_sd_a: assert property (mode_new && mode_data == CODE_SD |=> mode == MODE_SD)
        else $error("code FFh did not select step mode");
    sync_bit_a: assert property (status_word[SW_SYNC] |-> $past(cyclic && in_sync))
        else $error("sync bit set outside cyclic sync");
    follow_bit_a: assert property (quick_stop |=> !status_word[SW_FOLLOW])
        else $error("follow bit set during quick stop");
    cycle_index_a: assert property (ip_index != IDX_MS |=> !cycle_tick)
        else $error("cycle ran with unsupported index");
    trq_clamp_a: assert property (mode == MODE_CST |-> $signed(torque_cmd) <= $signed({1'b0, lim_t})
        && $signed(torque_cmd) >= -$signed({1'b0, lim_t}))
        else $error("torque above limit");
    trq_loop_a: assert property (mode == MODE_CST && !closed_loop |=> torque_cmd == '0)
        else $error("torque commanded without closed loop");
    acc_clear_a: assert property (tick_s |=> cleared_s)
        else $error("pulse count not cleared at cycle");
    ferr_mode_a: assert property (status_word[SW_FERR] |-> $past(mode == MODE_SD && closed_loop, 2))
        else $error("following error outside closed loop step mode");
    vel_clamp_a: assert property (sp_new && follow && mode == MODE_CSV && !quick_stop
        |=> $signed(vel_cmd) <= $signed({1'b0, max_speed}))
        else $error("speed above maximum");
endmodule // csd_drive

/* include/csd_pkg.sv */
// Constants for the cyclic setpoint and step/direction drive block
package csd_pkg;
    // ------------------------------------------------------------
    // Mode selection codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CSV = 8'h09;
    localparam logic [7:0] CODE_CST = 8'h0a;
    localparam logic [7:0] CODE_SD  = 8'hff;
    // ------------------------------------------------------------
    // Interpolation time base
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MS        = 8'hfd;
    localparam int         CLK_PERIOD_NS = 25;
    localparam int         T_BASE_NS     = 1000000;
    localparam int         MS_CYC_DEF    = T_BASE_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int SW_SYNC   = 8;
    localparam int SW_FOLLOW = 12;
    localparam int SW_FERR   = 13;
    // ------------------------------------------------------------
    // Step/direction
    // ------------------------------------------------------------
    localparam logic SUB_PULSE_DIR = 1'b0;
    localparam logic SUB_DUAL      = 1'b1;
    localparam int   FULL_STEPS_PP = 4;
    localparam int   SCALE_NUM_DEF = 128;
    localparam int   SCALE_DEN_DEF = 1;
    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_NONE, MODE_CSV, MODE_CST, MODE_SD} csd_mode_t;
endpackage

/* verilog/csd_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/100ps
module csd_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // csd_sync2

/* verilog/csd_xfer.sv */
// Toggle handshake carrying one word from the link clock to the core clock
`timescale 1ns/100ps
module csd_xfer #(
    parameter int W = 8
) (
    // Clocks and reset
    input  wire logic         src_clk,
    input  wire logic         dst_clk,
    input  wire logic         rst,
    // Source side
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_busy,
    // Destination side
    output logic              dst_valid,
    output logic      [W-1:0] dst_data
);
    logic         req;
    logic         ack;
    logic         req_s;
    logic         ack_s;
    logic [W-1:0] hold;

    csd_sync2 #(.W(1)) u_ack (.clk(src_clk), .rst(rst), .d(ack), .q(ack_s));
    csd_sync2 #(.W(1)) u_req (.clk(dst_clk), .rst(rst), .d(req), .q(req_s));

    assign src_busy = req ^ ack_s;

    // ------------------------------------------------------------
    // Source: hold word, flip request
    // ------------------------------------------------------------
    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) begin
            req  <= 1'b0;
            hold <= '0;
        end else if (src_valid && !src_busy) begin
            req  <= ~req;
            hold <= src_data;
        end
    end

    // ------------------------------------------------------------
    // Destination: capture word, return acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) begin
            ack       <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else begin
            dst_valid <= req_s ^ ack;
            ack       <= req_s;
            if (req_s ^ ack) begin
                dst_data <= hold;
            end
        end
    end
endmodule // csd_xfer

/* tb/csd_pulse_src.sv */
// Pulse source model driving the step/direction pins
`timescale 1ns/100ps
module csd_pulse_src (
    // Pins
    output logic din1,
    output logic din2
);
    initial begin
        din1 = 1'b0;
        din2 = 1'b0;
    end
    // Burst of n steps: 250 ns high, 1 us period
    task automatic burst(input int n, input logic neg, input logic dual);
        if (dual) begin
            din2 = 1'b0;
        end else if (din2 !== neg) begin
            din2 = neg;
            #35000;
        end
        repeat (n) begin
            if (dual && neg) din2 = 1'b1;
            else din1 = 1'b1;
            #250;
            din1 = 1'b0;
            if (dual) din2 = 1'b0;
            #750;
        end
    endtask
endmodule // csd_pulse_src

/* tb/csd_drive_bench.sv */
// Self-checking bench for the drive operating-mode block
`timescale 1ns/100ps
module csd_drive_bench;
    import csd_pkg::*;
    logic        clk, bus_clk, sys_rst, mode_wr, sp_wr, sync_evt, feed, din1, din2;
    logic        mode_busy, sp_busy, quick_stop, closed_loop, sd_subtype, qs_active, cycle_tick;
    logic [7:0]  mode_code, ip_period, ip_index, pole_pairs;
    logic [15:0] sp_val, max_speed, max_torque, max_current, vel_offset, torque_offset;
    logic [15:0] qs_decel, scale_num, scale_den, ferr_timeout, status_word, vel_cmd;
    logic [15:0] torque_cmd, steps_per_rev;
    logic [31:0] ferr_window, actual_pos, demand_pos;
    logic [2:0]  qs_option, qs_option_out;
    int          fail_count = 0, n_checks = 0, cyc = 0, gap = 0;
    csd_drive #(.MS_CYC(40)) i_dut (.clk(clk), .sys_rst(sys_rst), .bus_clk(bus_clk),
        .mode_wr(mode_wr), .mode_code(mode_code), .sp_wr(sp_wr), .sp_val(sp_val),
        .sync_evt(sync_evt), .mode_busy(mode_busy), .sp_busy(sp_busy), .ip_period(ip_period),
        .ip_index(ip_index), .max_speed(max_speed), .max_torque(max_torque),
        .max_current(max_current), .vel_offset(vel_offset), .torque_offset(torque_offset),
        .qs_decel(qs_decel), .qs_option(qs_option), .quick_stop(quick_stop),
        .closed_loop(closed_loop), .sd_subtype(sd_subtype), .scale_num(scale_num),
        .scale_den(scale_den), .pole_pairs(pole_pairs), .ferr_window(ferr_window),
        .ferr_timeout(ferr_timeout), .actual_pos(actual_pos), .din1(din1), .din2(din2),
        .status_word(status_word), .vel_cmd(vel_cmd), .torque_cmd(torque_cmd),
        .demand_pos(demand_pos), .qs_active(qs_active), .qs_option_out(qs_option_out),
        .steps_per_rev(steps_per_rev), .cycle_tick(cycle_tick));
    csd_pulse_src i_src (.din1(din1), .din2(din2));
    // ------------------------------------------------------------
    // Clocks, reset, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        bus_clk = 1'b0;
        #7;
        forever #24 bus_clk = ~bus_clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
    end
    // Sync and setpoint once every ten link clocks, about twice per cycle
    initial begin
        {sync_evt, sp_wr} = 2'b00;
        forever begin
            repeat (9) @(posedge bus_clk);
            #1 {sync_evt, sp_wr} = {feed, feed};
            @(posedge bus_clk);
            #1 {sync_evt, sp_wr} = 2'b00;
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick();
        do begin @(posedge clk); #1; end while (cycle_tick !== 1'b1);
    endtask
    task automatic wait_ticks(input int n);
        repeat (n) tick();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic mode_set(input logic [7:0] c);
        @(posedge bus_clk);
        while (mode_busy !== 1'b0) @(posedge bus_clk);
        #1 {mode_code, mode_wr} = {c, 1'b1};
        @(posedge bus_clk);
        #1 mode_wr = 1'b0;
        while (mode_busy !== 1'b0) @(posedge bus_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic cyclic(input logic [7:0] c, input logic cl, input logic [15:0] sp,
                          input logic [15:0] sw, input logic [15:0] cmd);
        {closed_loop, sp_val, feed} = {cl, sp, 1'b1};
        mode_set(c);
        wait_ticks(4);
        chk("status", {16'h0, sw}, {16'h0, status_word});
        chk("command", {16'h0, cmd}, {16'h0, (c == CODE_CSV) ? vel_cmd : torque_cmd});
    endtask
    task automatic qs_run();
        {quick_stop, qs_option} = {1'b1, 3'h5};
        wait_ticks(4);
        chk("qs state", {28'h0, 4'hd}, {28'h0, qs_active, qs_option_out});
        chk("qs speed", 32'h0, {16'h0, vel_cmd});
        chk("qs status", 32'h0100, {16'h0, status_word});
        quick_stop = 1'b0;
    endtask
    task automatic period_chk();
        ip_period = 8'h02;
        repeat (2) tick();
        gap = 0;
        do begin @(posedge clk); #1 gap++; end while (cycle_tick !== 1'b1);
        chk("tick gap", 32'd80, gap);
        {ip_index, gap} = {8'hfe, 32'h0};
        repeat (200) begin @(posedge clk); #1 if (cycle_tick === 1'b1) gap++; end
        chk("no ticks", 32'h0, gap);
        {ip_index, ip_period} = {IDX_MS, 8'h01};
    endtask
    task automatic sd(input int n, input logic neg, input logic dual, input logic [31:0] e);
        sd_subtype = dual;
        i_src.burst(n, neg, dual);
        wait_ticks(2);
        chk("demand", e, demand_pos);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {quick_stop, closed_loop, sd_subtype, mode_wr, feed, qs_option} = 8'h00;
        {mode_code, ip_period, ip_index, pole_pairs} = {8'h00, 8'h01, IDX_MS, 8'h03};
        {max_speed, max_torque, max_current} = {16'h03e8, 16'h01f4, 16'h012c};
        {vel_offset, torque_offset, qs_decel} = {16'h0005, 16'h0014, 16'h0258};
        {sp_val, scale_num, scale_den, ferr_timeout} = {16'h0, 16'h0080, 16'h0001, 16'h0002};
        {ferr_window, actual_pos} = {32'h0a, 32'h0};
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk("reset status", 32'h0, {16'h0, status_word});
        cyclic(CODE_CSV, 1'b0, 16'h07d0, 16'h1100, 16'h03e8);
        cyclic(CODE_CSV, 1'b0, 16'h0064, 16'h1100, 16'h0069);
        cyclic(CODE_CST, 1'b1, 16'h00c8, 16'h1100, 16'h00dc);
        cyclic(CODE_CST, 1'b1, 16'h0190, 16'h1100, 16'h012c);
        cyclic(CODE_CST, 1'b0, 16'h00c8, 16'h0100, 16'h0000);
        cyclic(CODE_CSV, 1'b0, 16'h07d0, 16'h1100, 16'h03e8);
        qs_run();
        feed = 1'b0;
        wait_ticks(3);
        chk("idle status", 32'h0, {16'h0, status_word});
        chk("sp idle", 32'h0, {31'h0, sp_busy});
        period_chk();
        mode_set(CODE_SD);
        chk("steps rev", 32'd12, {16'h0, steps_per_rev});
        sd(3, 1'b0, 1'b0, 32'h180);
        sd(1, 1'b1, 1'b0, 32'h100);
        sd(2, 1'b0, 1'b1, 32'h200);
        sd(1, 1'b1, 1'b1, 32'h180);
        {scale_num, scale_den} = {16'h0200, 16'h0002};
        sd(1, 1'b0, 1'b0, 32'h280);
        closed_loop = 1'b1;
        wait_ticks(5);
        chk("ferr set", 32'h2000, {16'h0, status_word});
        actual_pos = 32'h280;
        wait_ticks(2);
        chk("ferr clear", 32'h0, {16'h0, status_word});
        end_of_test();
    end
endmodule // csd_drive_bench
